// *** cfpf_pkg.sv ***
// Purpose: constants and types for the cell fault protection controller
// Assumes: 20 MHz system clock, 10 kHz delay tick derived from it
// Notes: delay tables hold the four factory settings of the undervoltage, discharge oc and charge oc timers
//
// Operation
// - long undervoltage drops discharge gate, over-discharge
// - over-discharge pulls sense up; small gap powers down
// - sink off in power-down and over-discharge
// - gap above 1.3 V leaves power-down
// - charger below -0.7 V: release at threshold
// - otherwise release at threshold plus hysteresis
// - persistent discharge overcurrent drops discharge gate
// - discharge overcurrent connects the current sink
// - discharge overcurrent keeps pull-up disconnected
// - sense 1 V below cell returns normal
// - persistent charge overcurrent drops charge gate
// - sense back above threshold returns normal
// - no charge overcurrent check in over-discharge
// - charge overcurrent: pull-up and sink disconnected
// - zero-volt charge: gate follows cell, then normal
// - zero-volt charge beats charge overcurrent check
// - below inhibit level charge gate held low
// - all delays timed by 10 kHz tick
// - plain overcurrent waits full overcurrent delay
// - short circuit uses short fixed delay
// - recovery timer before gate re-enable
// - short delay fixed 250 us, recovery fixed 1 ms, others selectable
// - overcurrent delay tables, four settings each
package cfpf_pkg;

    //------------------------------------------------------------
    // timing
    //------------------------------------------------------------
    localparam int CLK_HZ        = 20_000_000; // system clock rate
    localparam int TICK_HZ       = 10_000;     // delay tick rate
    localparam int TICK_CYCLES   = CLK_HZ / TICK_HZ;
    localparam int TICKS_PER_MS  = TICK_HZ / 1000;
    localparam int SHORT_DELAY_US = 250;       // fixed short delay
    // least time: round up to whole ticks
    localparam int SHORT_TICKS   = (SHORT_DELAY_US * TICK_HZ + 999_999)
                                   / 1_000_000;
    localparam int REC_DELAY_MS  = 1;          // recovery delay
    localparam int REC_TICKS     = REC_DELAY_MS * TICKS_PER_MS;
    localparam int CNT_W         = 11;         // fits 1440 ticks

    // factory delay tables in ms
    localparam int UV_DELAY_MS  [4] = '{20, 96, 125, 144};
    localparam int DOC_DELAY_MS [4] = '{8, 16, 20, 48};
    localparam int COC_DELAY_MS [4] = '{4, 6, 8, 16};

    // detector indices
    localparam int DET_UV = 0;
    localparam int DET_DOC = 1;
    localparam int DET_SHORT = 2;
    localparam int DET_COC = 3;
    localparam int NUM_DET = 4;

    //------------------------------------------------------------
    // register map
    //------------------------------------------------------------
    localparam logic [7:0]  CONFIG_ADDR  = 8'h00;
    localparam logic [7:0]  STATUS_ADDR  = 8'h04;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam int CFG_UV_POS  = 0;  // [1:0] undervoltage delay
    localparam int CFG_DOC_POS = 2;  // [3:2] discharge oc delay
    localparam int CFG_COC_POS = 4;  // [5:4] charge oc delay

    // one-hot fault states
    typedef enum logic [4:0] {
        ST_NORMAL   = 5'h01,
        ST_OVER_DIS = 5'h02,
        ST_DIS_OC   = 5'h04,
        ST_CHG_OC   = 5'h08,
        ST_ZERO_V   = 5'h10
    } cfpf_state_type;

    // comparator results from the analog front end
    typedef struct packed {
        logic cell_below_uv;      // cell under undervoltage_threshold
        logic cell_above_hys;     // cell over threshold plus hysteresis
        logic sense_below_neg07;  // sense pin below -0.7 V
        logic sense_gap_gt_1v3;   // sense to cell gap above 1.3 V
        logic sense_ge_dis_oc;    // discharge_overcurrent threshold
        logic sense_ge_short;     // load_short_circuit threshold
        logic sense_below_coc;    // under charge overcurrent threshold
        logic sense_le_cell_1v;   // sense at cell minus 1 V or lower
        logic charger_at_start;   // zero_volt_charge_start_level met
        logic cell_below_inh;     // under zero_volt_inhibit_level
    } cfpf_cmp_type;

endpackage : cfpf_pkg

// *** cfpf_top.sv ***
// Purpose: fault state controller driving charge and discharge gates
// Assumes: comparator levels arrive asynchronously from analog pins
// Notes: configuration and status reached over APB, zero wait state while CE_IN is high
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module cfpf_top #(
    parameter int TICK_DIV = cfpf_pkg::TICK_CYCLES // cycles per tick
) (
    // clock, reset, enable
    input  wire logic                 CLK_IN,
    input  wire logic                 RST_N_IN,
    input  wire logic                 CE_IN,
    // analog comparator results
    input  wire cfpf_pkg::cfpf_cmp_type COMPARATOR_IN,
    // apb slave
    input  wire logic                 APB_PSEL_IN,
    input  wire logic                 APB_PENABLE_IN,
    input  wire logic                 APB_PWRITE_IN,
    input  wire logic [7:0]           APB_PADDR_IN,
    input  wire logic [31:0]          APB_PWDATA_IN,
    output logic      [31:0]          APB_PRDATA_OUT,
    output logic                      APB_PREADY_OUT,
    output logic                      APB_PSLVERR_OUT,
    // gate drives and sense switches
    output logic                      DISCHARGE_GATE_OUT,
    output logic                      CHARGE_GATE_OUT,
    output logic                      CHARGE_FOLLOW_OUT,
    output logic                      PULLUP_EN_OUT,
    output logic                      SINK_EN_OUT,
    output logic                      POWER_DOWN_OUT,
    output logic      [4:0]           STATE_OUT
);
    import cfpf_pkg::*;

    //------------------------------------------------------------
    // comparator synchroniser
    //------------------------------------------------------------
    cfpf_cmp_type cmp_meta_q;   // first stage, read only by second
    cfpf_cmp_type cmp_q;        // safe comparator levels

    // two flops per level; levels are slow, no glitch filter needed
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            cmp_meta_q <= '0;
            cmp_q      <= '0;
        end else if (CE_IN) begin
            cmp_meta_q <= COMPARATOR_IN;
            cmp_q      <= cmp_meta_q;
        end
    end

    //------------------------------------------------------------
    // 10 kHz tick
    //------------------------------------------------------------
    logic [15:0] tick_cnt_q;    // cycle counter inside a tick
    logic        tick;          // one cycle per tick period

    assign tick = (tick_cnt_q == 16'(TICK_DIV - 1));

    // free running divider; all delays step on this pulse
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            tick_cnt_q <= '0;
        end else if (CE_IN) begin
            if (tick) begin
                tick_cnt_q <= '0;
            end else begin
                tick_cnt_q <= tick_cnt_q + 16'h0001;
            end
        end
    end

    //------------------------------------------------------------
    // configuration register
    //------------------------------------------------------------
    logic [31:0] config_q;      // delay selections
    logic        apb_access;    // access phase
    logic        apb_mapped;    // address hits a register

    assign apb_access     = APB_PSEL_IN & APB_PENABLE_IN;
    assign apb_mapped     = (APB_PADDR_IN == CONFIG_ADDR) |
                            (APB_PADDR_IN == STATUS_ADDR);
    // frozen logic must not complete transfers
    assign APB_PREADY_OUT  = CE_IN;
    assign APB_PSLVERR_OUT = apb_access & ~apb_mapped;

    // write lands at the completing edge only
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            config_q <= CONFIG_RESET;
        end else if (CE_IN) begin
            if (apb_access && APB_PWRITE_IN &&
                (APB_PADDR_IN == CONFIG_ADDR)) begin
                config_q <= {26'h0, APB_PWDATA_IN[5:0]};
            end
        end
    end

    //------------------------------------------------------------
    // detection delay counters
    //------------------------------------------------------------
    cfpf_state_type   state_q;              // fault state
    cfpf_state_type   state_d;              // next fault state
    logic [CNT_W-1:0] det_lim [NUM_DET];    // expiry count per detector
    logic [NUM_DET-1:0] det_cmp;            // comparator asserted
    logic [NUM_DET-1:0] det_exp;            // persisted long enough
    logic [1:0]       uv_sel;               // undervoltage delay choice
    logic [1:0]       doc_sel;              // discharge oc delay choice
    logic [1:0]       coc_sel;              // charge oc delay choice

    assign uv_sel  = config_q[CFG_UV_POS +: 2];
    assign doc_sel = config_q[CFG_DOC_POS +: 2];
    assign coc_sel = config_q[CFG_COC_POS +: 2];

    // selectable delays, short delay fixed
    assign det_lim[DET_UV]    = CNT_W'(UV_DELAY_MS[uv_sel] *
                                       TICKS_PER_MS);
    assign det_lim[DET_DOC]   = CNT_W'(DOC_DELAY_MS[doc_sel] *
                                       TICKS_PER_MS);
    assign det_lim[DET_SHORT] = CNT_W'(SHORT_TICKS);
    assign det_lim[DET_COC]   = CNT_W'(COC_DELAY_MS[coc_sel] *
                                       TICKS_PER_MS);

    // detection only runs in normal status
    assign det_cmp[DET_UV]    = (state_q == ST_NORMAL) &
                                cmp_q.cell_below_uv;
    assign det_cmp[DET_DOC]   = (state_q == ST_NORMAL) &
                                cmp_q.sense_ge_dis_oc;
    assign det_cmp[DET_SHORT] = (state_q == ST_NORMAL) &
                                cmp_q.sense_ge_short;
    // no charge oc check with a depleted cell
    assign det_cmp[DET_COC]   = (state_q == ST_NORMAL) &
                                cmp_q.sense_below_coc &
                                ~cmp_q.cell_below_uv;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_DET; gi++) begin : g_det
            logic [CNT_W-1:0] cnt_q; // ticks of continuous fault

            assign det_exp[gi] = det_cmp[gi] & (cnt_q >= det_lim[gi]);

            // counts while asserted, clears on any drop
            always_ff @(posedge CLK_IN) begin
                if (!RST_N_IN) begin
                    cnt_q <= '0;
                end else if (CE_IN) begin
                    if (!det_cmp[gi]) begin
                        cnt_q <= '0;
                    end else if (tick && (cnt_q < det_lim[gi])) begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
            end
        end
    endgenerate

    //------------------------------------------------------------
    // recovery timer
    //------------------------------------------------------------
    logic             rec_cond;   // release condition holds
    logic [CNT_W-1:0] rec_cnt_q;  // ticks of held release
    logic             rec_done;   // release has held long enough

    // release condition for each fault state
    always_comb begin
        rec_cond = 1'b0;
        unique case (state_q)
            // zero-volt charge releases at the over-discharge levels
            ST_OVER_DIS, ST_ZERO_V: begin
                if (cmp_q.sense_below_neg07) begin
                    rec_cond = ~cmp_q.cell_below_uv;
                end else begin
                    rec_cond = cmp_q.cell_above_hys;
                end
            end
            ST_DIS_OC:   rec_cond = cmp_q.sense_le_cell_1v;
            ST_CHG_OC:   rec_cond = ~cmp_q.sense_below_coc;
            ST_NORMAL:   rec_cond = 1'b0;
            default:     rec_cond = 1'b0;
        endcase
    end

    assign rec_done = rec_cond & (rec_cnt_q >= CNT_W'(REC_TICKS));

    // recurrence of the fault restarts the wait
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            rec_cnt_q <= '0;
        end else if (CE_IN) begin
            if (!rec_cond || (state_d != state_q)) begin
                rec_cnt_q <= '0;
            end else if (tick && !rec_done) begin
                rec_cnt_q <= rec_cnt_q + CNT_W'(1);
            end
        end
    end

    //------------------------------------------------------------
    // fault state machine
    //------------------------------------------------------------
    // undervoltage first, short and overcurrent share discharge
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_NORMAL: begin
                if (det_exp[DET_UV]) begin
                    state_d = ST_OVER_DIS;
                end else if (det_exp[DET_SHORT]) begin
                    state_d = ST_DIS_OC;
                end else if (det_exp[DET_DOC]) begin
                    state_d = ST_DIS_OC;
                end else if (det_exp[DET_COC]) begin
                    state_d = ST_CHG_OC;
                end
            end
            ST_OVER_DIS: begin
                if (rec_done) begin
                    state_d = ST_NORMAL;
                end else if (cmp_q.charger_at_start &&
                             !cmp_q.cell_below_inh) begin
                    state_d = ST_ZERO_V;
                end
            end
            ST_DIS_OC: begin
                if (rec_done) begin
                    state_d = ST_NORMAL;
                end
            end
            ST_CHG_OC: begin
                if (rec_done) begin
                    state_d = ST_NORMAL;
                end
            end
            ST_ZERO_V: begin
                if (rec_done) begin
                    state_d = ST_NORMAL;
                end else if (!cmp_q.charger_at_start) begin
                    state_d = ST_OVER_DIS;
                end
            end
            // illegal one-hot code: fall back to safe over-discharge
            default: state_d = ST_OVER_DIS;
        endcase
    end

    // state register
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            state_q <= ST_NORMAL;
        end else if (CE_IN) begin
            state_q <= state_d;
        end
    end

    //------------------------------------------------------------
    // power-down flag
    //------------------------------------------------------------
    logic power_down_q; // low current condition in over-discharge

    // a charger widening the gap wakes the device
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            power_down_q <= 1'b0;
        end else if (CE_IN) begin
            if (state_q != ST_OVER_DIS) begin
                power_down_q <= 1'b0;
            end else if (cmp_q.sense_gap_gt_1v3) begin
                power_down_q <= 1'b0;
            end else begin
                power_down_q <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------
    // output drive
    //------------------------------------------------------------
    logic dis_fault;  // any discharge-side fault latched
    logic chg_fault;  // charge oc state, or cell below inhibit level

    assign dis_fault = (state_q == ST_OVER_DIS) |
                       (state_q == ST_DIS_OC) |
                       (state_q == ST_ZERO_V);
    assign chg_fault = (state_q == ST_CHG_OC) |
                       cmp_q.cell_below_inh;

    // gate and switch flops; one cycle behind the state
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            DISCHARGE_GATE_OUT <= 1'b0;
            CHARGE_GATE_OUT    <= 1'b0;
            CHARGE_FOLLOW_OUT  <= 1'b0;
            PULLUP_EN_OUT      <= 1'b0;
            SINK_EN_OUT        <= 1'b0;
            POWER_DOWN_OUT     <= 1'b0;
            STATE_OUT          <= 5'h00;
        end else if (CE_IN) begin
            DISCHARGE_GATE_OUT <= ~dis_fault;
            CHARGE_GATE_OUT    <= ~chg_fault;
            CHARGE_FOLLOW_OUT  <= (state_q == ST_ZERO_V) &
                                  ~cmp_q.cell_below_inh;
            PULLUP_EN_OUT      <= (state_q == ST_OVER_DIS);
            // sink off in power-down, over-discharge, charge oc
            SINK_EN_OUT        <= (state_q == ST_DIS_OC);
            POWER_DOWN_OUT     <= power_down_q;
            STATE_OUT          <= state_q;
        end
    end

    // read data captured in the setup phase
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            APB_PRDATA_OUT <= 32'h0000_0000;
        end else if (CE_IN && APB_PSEL_IN && !APB_PENABLE_IN) begin
            if (APB_PADDR_IN == CONFIG_ADDR) begin
                APB_PRDATA_OUT <= config_q;
            end else if (APB_PADDR_IN == STATUS_ADDR) begin
                APB_PRDATA_OUT <= {21'h0, CHARGE_FOLLOW_OUT,
                                   SINK_EN_OUT, PULLUP_EN_OUT,
                                   CHARGE_GATE_OUT, DISCHARGE_GATE_OUT,
                                   power_down_q, state_q};
            end else begin
                APB_PRDATA_OUT <= 32'h0000_0000;
            end
        end
    end

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_uv_entry: assert property (
        CE_IN && state_q == ST_NORMAL && det_exp[DET_UV]
        |=> state_q == ST_OVER_DIS ##1 !DISCHARGE_GATE_OUT)
        else $error("undervoltage did not enter over-discharge");
    a_power_down: assert property (
        CE_IN && state_q == ST_OVER_DIS && !cmp_q.sense_gap_gt_1v3
        |=> power_down_q)
        else $error("power-down not entered");
    a_sink_off_od: assert property (
        CE_IN && (state_q == ST_OVER_DIS || power_down_q)
        |=> !SINK_EN_OUT &&
            (PULLUP_EN_OUT == $past(state_q == ST_OVER_DIS)))
        else $error("sink active in over-discharge");
    a_pd_wake: assert property (
        CE_IN && power_down_q && cmp_q.sense_gap_gt_1v3
        |=> !power_down_q)
        else $error("power-down not released");
    a_od_release: assert property (
        CE_IN && state_q == ST_OVER_DIS && rec_done
        |=> state_q == ST_NORMAL ##1 DISCHARGE_GATE_OUT)
        else $error("over-discharge release missed");
    a_doc_entry: assert property (
        CE_IN && state_q == ST_NORMAL && !det_exp[DET_UV] &&
        (det_exp[DET_DOC] || det_exp[DET_SHORT])
        |=> state_q == ST_DIS_OC)
        else $error("discharge overcurrent not entered");
    a_doc_switches: assert property (
        CE_IN && state_q == ST_DIS_OC |=> SINK_EN_OUT && !PULLUP_EN_OUT)
        else $error("discharge oc switches wrong");
    a_coc_switches: assert property (
        CE_IN && state_q == ST_CHG_OC
        |=> !SINK_EN_OUT && !PULLUP_EN_OUT && !CHARGE_GATE_OUT)
        else $error("charge oc switches wrong");
    a_coc_blocked: assert property (
        state_q == ST_OVER_DIS |-> !det_cmp[DET_COC])
        else $error("charge oc detection in over-discharge");
    a_inhibit_low: assert property (
        CE_IN && cmp_q.cell_below_inh |=> !CHARGE_GATE_OUT)
        else $error("charge gate high below inhibit level");
    a_short_fast: assert property (
        CE_IN && state_q == ST_NORMAL && !det_exp[DET_UV] &&
        det_exp[DET_SHORT] |=> state_q == ST_DIS_OC)
        else $error("short circuit not acted on");
    a_tick_spacing: assert property (
        tick && CE_IN |=> !tick)
        else $error("tick pulses too close");

    c_uv_fault:   cover property (state_q == ST_OVER_DIS);
    c_doc_fault:  cover property (state_q == ST_DIS_OC);
    c_coc_fault:  cover property (state_q == ST_CHG_OC);
    c_zero_volt:  cover property (state_q == ST_ZERO_V ##1
                                  state_q == ST_NORMAL);

endmodule // cfpf_top

// *** cfpf_far_side.sv ***
// Purpose: far side model: cell, load, charger and fet sense levels
// Assumes: bench picks cell millivolts, load mode and charger mode
// Notes: pure levels; the block's own switches shape the sense pin
`timescale 1ns/1ns
module cfpf_far_side #(
    parameter int UV_MV  = 2800, // undervoltage_threshold, plain default
    parameter int HYS_MV = 2900, // threshold plus hysteresis
    parameter int INH_MV = 1000  // zero_volt_inhibit_level
) (
    // scenario choices from the bench
    input  wire logic [15:0]    cell_mv_in, // cell voltage in mV
    input  wire logic [1:0]     load_in,    // 0 none 1 ok 2 over 3 short
    input  wire logic [1:0]     charger_in, // 0 none 1 ok 2 over-current
    // switch states from the block
    input  wire logic           dis_gate_in,
    input  wire logic           pullup_in,
    // comparator levels to the block
    output cfpf_pkg::cfpf_cmp_type cmp_out
);
    import cfpf_pkg::*;
    logic chg_on; // charger on the pack
    logic loaded; // load across the pack
    logic stuck;  // dsg off under load: sense rises to cell
    assign chg_on = (charger_in != 2'h0);
    assign loaded = (load_in != 2'h0);
    assign stuck  = loaded && !dis_gate_in;
    // cell comparators
    assign cmp_out.cell_below_uv  = (int'(cell_mv_in) < UV_MV);
    assign cmp_out.cell_above_hys = (int'(cell_mv_in) > HYS_MV);
    assign cmp_out.cell_below_inh = (int'(cell_mv_in) < INH_MV);
    // a charger drags sense below ground, far from the cell
    assign cmp_out.sense_below_neg07 = chg_on;
    assign cmp_out.sense_gap_gt_1v3  = chg_on;
    assign cmp_out.charger_at_start  = chg_on;
    assign cmp_out.sense_below_coc   = (charger_in == 2'h2);
    // load current lifts sense; an open dsg fet leaves it at cell
    assign cmp_out.sense_ge_dis_oc = (load_in >= 2'h2) || stuck;
    assign cmp_out.sense_ge_short  = (load_in == 2'h3) || stuck;
    // pull-up holds sense at cell and a load lifts it, otherwise it sits low
    assign cmp_out.sense_le_cell_1v = chg_on || (!loaded && !pullup_in);
endmodule // cfpf_far_side

// *** cell_fault_protection_fsm_tb_top.sv ***
// Purpose: self-checking bench for the cell fault state controller
// Assumes: short tick divider so every delay fits a short run
// Notes: rows walk the fault states in order, state carries over
`timescale 1ns/1ns
module cell_fault_protection_fsm_tb_top;
    import cfpf_pkg::*;
    localparam int TDIV = 4; // cycles per tick, shortened
    typedef struct {
        int         mv;  // cell millivolts
        logic [1:0] ld;  // load mode
        logic [1:0] ch;  // charger mode
        int         cyc; // cycles to settle
        logic [4:0] st;  // expected state
        logic [5:0] o;   // dis chg pullup sink powerdown follow
    } cfpf_row_type;
    cfpf_row_type rows [13] = '{
        '{3600, 2'h1, 2'h0,  50, 5'h01, 6'h30},
        '{3600, 2'h2, 2'h0, 400, 5'h04, 6'h14},
        '{3600, 2'h0, 2'h0, 100, 5'h01, 6'h30},
        '{3600, 2'h0, 2'h2, 250, 5'h08, 6'h20},
        '{3600, 2'h0, 2'h0, 100, 5'h01, 6'h30},
        '{2500, 2'h0, 2'h0, 900, 5'h02, 6'h1A},
        '{2850, 2'h0, 2'h0, 100, 5'h02, 6'h1A},
        '{2950, 2'h0, 2'h0, 100, 5'h01, 6'h30},
        '{2500, 2'h0, 2'h0, 900, 5'h02, 6'h1A},
        '{2500, 2'h0, 2'h2, 100, 5'h10, 6'h11},
        '{2850, 2'h0, 2'h1, 100, 5'h01, 6'h30},
        '{ 500, 2'h0, 2'h0,  20, 5'h01, 6'h20},
        '{3600, 2'h0, 2'h0,  20, 5'h01, 6'h30}
    };
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, perr, er, dis, chg, fol, pull, sink, pd;
    logic [4:0] st;
    logic [15:0] mv = 16'd3600;
    logic [1:0] ld = 2'h0, ch = 2'h0;
    cfpf_cmp_type cmp;
    logic [31:0] outv; // dis chg pullup sink powerdown follow
    assign outv = {26'h0, dis, chg, pull, sink, pd, fol};
    int bad_count = 0, check_count = 0;
    always #25 clk = ~clk;
    cfpf_far_side far (.cell_mv_in(mv), .load_in(ld), .charger_in(ch),
        .dis_gate_in(dis), .pullup_in(pull), .cmp_out(cmp));
    cfpf_top #(.TICK_DIV(TDIV)) uut (.CLK_IN(clk), .RST_N_IN(rst_n),
        .CE_IN(ce), .COMPARATOR_IN(cmp), .APB_PSEL_IN(psel),
        .APB_PENABLE_IN(pen), .APB_PWRITE_IN(pwr), .APB_PADDR_IN(paddr),
        .APB_PWDATA_IN(pwdata), .APB_PRDATA_OUT(prdata),
        .APB_PREADY_OUT(pready), .APB_PSLVERR_OUT(perr),
        .DISCHARGE_GATE_OUT(dis), .CHARGE_GATE_OUT(chg),
        .CHARGE_FOLLOW_OUT(fol), .PULLUP_EN_OUT(pull),
        .SINK_EN_OUT(sink), .POWER_DOWN_OUT(pd), .STATE_OUT(st));
    // one apb transfer; read data and error land in rd and er
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        // no wait is bounded here; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog: whole run needs well under 10000 cycles
    initial begin
        #1_000_000;
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        chk(outv, 32'h0);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk({27'h0, st}, 32'h01);
        apb(1'b1, 8'h00, 32'hFFFF_FFFF);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h3F);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'hC1);
        chk({31'h0, er}, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h00, 32'h0C);
        ld <= 2'h2; // longest discharge setting outlasts default
        repeat (600) @(posedge clk);
        chk({27'h0, st}, 32'h01);
        ld <= 2'h0;
        apb(1'b1, 8'h00, 32'h0);
        foreach (rows[i]) begin
            mv <= 16'(rows[i].mv);
            ld <= rows[i].ld;
            ch <= rows[i].ch;
            repeat (rows[i].cyc) @(posedge clk);
            chk({27'h0, st}, {27'h0, rows[i].st});
            chk(outv, {26'h0, rows[i].o});
        end
        ld <= 2'h3; // short trips on its fixed short delay
        repeat (8) @(posedge clk);
        chk({31'h0, dis}, 32'h1);
        repeat (16) @(posedge clk);
        chk({31'h0, dis}, 32'h0);
        ld <= 2'h0;
        repeat (100) @(posedge clk);
        chk({27'h0, st}, 32'h01);
        ld <= 2'h2; // broken overload must restart its count
        repeat (200) @(posedge clk);
        ld <= 2'h1;
        repeat (20) @(posedge clk);
        ld <= 2'h2;
        repeat (200) @(posedge clk);
        chk({31'h0, dis}, 32'h1);
        ce <= 1'b0; // frozen block must ride out the overload
        repeat (400) @(posedge clk);
        chk({31'h0, pready}, 32'h0);
        chk({27'h0, st}, 32'h01);
        chk(outv, 32'h30);
        ce <= 1'b1;
        ld <= 2'h0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({27'h0, st}, 32'h0);
        rst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        stop_test();
    end
endmodule // cell_fault_protection_fsm_tb_top
